// File: cuf_top.sv
// Counter user input function block with APB registers and serial print path
//
// Decided for this implementation: the APB interface to the registers and the address map.
module cuf_top
    import cuf_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [2:0]  user_in_i,
    input  wire logic        panel_function_key_i,
    input  wire logic        batch_model_i,
    input  wire logic        prog_disable_lvl1_i,
    output logic             display_freeze_o,
    output logic             counter1_reset_o,
    output logic             counter2_reset_o,
    output logic             count_inhibit_o,
    output logic             program_disable_o,
    output logic             outputs_reset_o,
    output logic             display_advance_o,
    output logic             tx_o
);
    import cuf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] func_q;
    logic [31:0] cfg_q;
    logic [7:0]  code_q;
    logic [7:0]  code_entry_q;
    logic [31:0] txdata_q;
    logic [3:0]  fn [N_SRC];

    // Config fields: [1:0] selector, [2] scroll, [4:3] baud, [6:5] parity,
    // [7] abbreviate, [14:8] address, [15] stored but unused
    logic [1:0]  sel_w;
    logic        scroll_w;
    logic [1:0]  baud_w;
    logic [1:0]  par_w;
    logic        abbr_w;
    logic [6:0]  addr_w;
    assign sel_w    = cfg_q[1:0];
    assign scroll_w = cfg_q[2];
    assign baud_w   = cfg_q[4:3];
    assign par_w    = cfg_q[6:5];
    assign abbr_w   = cfg_q[7];
    assign addr_w   = cfg_q[14:8];

    // Hold class test, used by the assignment check
    function automatic logic is_hold(input logic [3:0] f);
        return (f == FN_HOLD) || (f == FN_HOLD_LVL) || (f == FN_HOLD_EDGE);
    endfunction

    // Whether a source may take a function
    function automatic logic allowed(input int unsigned s, input logic [3:0] f,
                                     input logic batch);
        logic ok;
        ok = (f <= FN_RST_OUT);
        if (f == FN_INHIBIT && s != SRC_IN1)
            ok = 1'b0;
        if (s == SRC_KEY && (f == FN_INHIBIT || f == FN_PROG_DIS))
            ok = 1'b0;
        if (!batch && (f >= FN_RST2_LVL) && (f <= FN_RSTALL_EDGE))
            ok = 1'b0;
        return ok;
    endfunction

    logic wr_w;
    logic rd_w;
    logic code_ok_w;
    logic func_ok_w;
    assign wr_w = psel_i && penable_i && pwrite_i;
    assign rd_w = psel_i && penable_i && !pwrite_i;
    assign pready_o = 1'b1;

    // Reject a mapping that gives hold to more than one source
    always_comb begin
        int unsigned holds;
        holds = 0;
        func_ok_w = 1'b1;
        for (int unsigned s = 0; s < N_SRC; s++) begin
            if (is_hold(pwdata_i[4*s +: 4]))
                holds++;
            if (!allowed(s, pwdata_i[4*s +: 4], batch_model_i))
                func_ok_w = 1'b0;
        end
        if (holds > 1)
            func_ok_w = 1'b0;
    end
    assign code_ok_w = (pwdata_i[7:0] <= CODE_MAX);

    // Bad writes and unmapped addresses answer with an error
    always_comb begin
        pslverr_o = 1'b0;
        if (psel_i && penable_i) begin
            case (paddr_i)
                REG_FUNC:   pslverr_o = pwrite_i && !func_ok_w;
                REG_CFG:    pslverr_o = 1'b0;
                REG_CODE:   pslverr_o = pwrite_i && !code_ok_w;
                REG_STAT:   pslverr_o = pwrite_i;
                REG_TXDATA: pslverr_o = 1'b0;
                default:    pslverr_o = 1'b1;
            endcase
        end
    end

    // Register writes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            func_q       <= 16'h0000;
            cfg_q        <= CFG_RESET;
            code_q       <= 8'h00;
            code_entry_q <= 8'h00;
            txdata_q     <= 32'h0000_0000;
        end else if (wr_w && !pslverr_o) begin
            case (paddr_i)
                REG_FUNC:   func_q <= pwdata_i[15:0];
                REG_CFG:    cfg_q <= {16'h0000, pwdata_i[15:0]};
                REG_CODE:   code_q <= pwdata_i[7:0];
                REG_STAT:   code_entry_q <= pwdata_i[7:0];
                REG_TXDATA: txdata_q <= pwdata_i;
                default:    code_q <= code_q;
            endcase
        end
    end
    // Entered code takes the low byte of a write at the status offset; status writes are refused, so it keeps its reset zero
    logic [7:0] entered_w;
    assign entered_w = code_entry_q;

    for (genvar s = 0; s < N_SRC; s++) begin : g_fn
        assign fn[s] = func_q[4*s +: 4];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection
    logic [N_SRC-1:0] meta_q;
    logic [N_SRC-1:0] sync_q;
    logic [N_SRC-1:0] prev_q;
    logic [N_SRC-1:0] act_w;
    logic [N_SRC-1:0] rise_w;

    // Two stages; only the second feeds logic
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= {panel_function_key_i, user_in_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Input B is masked unless the selector frees it
    always_comb begin
        act_w = sync_q;
        if (sel_w != SEL_C1_USR && sel_w != SEL_C2_USR)
            act_w[SRC_INB] = 1'b0;
        rise_w = act_w & ~prev_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Function decode
    logic [N_SRC-1:0] hold_w;
    logic [N_SRC-1:0] lvl1_w;
    logic [N_SRC-1:0] lvl2_w;
    logic [N_SRC-1:0] pulse1_w;
    logic [N_SRC-1:0] pulse2_w;
    logic [N_SRC-1:0] chg_w;
    logic [N_SRC-1:0] pdis_w;
    logic [N_SRC-1:0] inh_w;
    logic [N_SRC-1:0] prt_w;
    logic [N_SRC-1:0] rout_w;

    always_comb begin
        for (int unsigned s = 0; s < N_SRC; s++) begin
            hold_w[s]   = act_w[s] && is_hold(fn[s]);
            lvl1_w[s]   = act_w[s] && (fn[s] == FN_RST_LVL || fn[s] == FN_RSTALL_LVL
                          || (fn[s] == FN_HOLD_LVL && !batch_model_i));
            lvl2_w[s]   = act_w[s] && (fn[s] == FN_RST2_LVL || fn[s] == FN_RSTALL_LVL
                          || (fn[s] == FN_HOLD_LVL && batch_model_i));
            pulse1_w[s] = rise_w[s] && (fn[s] == FN_RST_EDGE || fn[s] == FN_RSTALL_EDGE
                          || (fn[s] == FN_HOLD_EDGE && !batch_model_i));
            pulse2_w[s] = rise_w[s] && (fn[s] == FN_RST2_EDGE || fn[s] == FN_RSTALL_EDGE
                          || (fn[s] == FN_HOLD_EDGE && batch_model_i));
            chg_w[s]    = rise_w[s] && (fn[s] == FN_CHG_DISP);
            pdis_w[s]   = act_w[s] && (fn[s] == FN_PROG_DIS);
            inh_w[s]    = act_w[s] && (fn[s] == FN_INHIBIT) && (s == SRC_IN1);
            prt_w[s]    = act_w[s] && (fn[s] == FN_PRINT);
            rout_w[s]   = rise_w[s] && (fn[s] == FN_RST_OUT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto scroll timer
    logic [31:0] scroll_cnt_q;
    logic        scroll_tick_w;
    assign scroll_tick_w = scroll_w && (scroll_cnt_q == 32'(SCROLL_CYC - 1));

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            scroll_cnt_q <= '0;
        else if (!scroll_w || scroll_tick_w)
            scroll_cnt_q <= '0;
        else
            scroll_cnt_q <= scroll_cnt_q + 32'h1;
    end

    // Registered control outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            display_freeze_o  <= 1'b0;
            counter1_reset_o  <= 1'b0;
            counter2_reset_o  <= 1'b0;
            count_inhibit_o   <= 1'b0;
            program_disable_o <= 1'b0;
            outputs_reset_o   <= 1'b0;
            display_advance_o <= 1'b0;
        end else begin
            display_freeze_o  <= |hold_w;
            counter1_reset_o  <= |lvl1_w || |pulse1_w;
            counter2_reset_o  <= |lvl2_w || |pulse2_w;
            count_inhibit_o   <= |inh_w;
            program_disable_o <= |pdis_w;
            outputs_reset_o   <= |rout_w;
            display_advance_o <= |chg_w || scroll_tick_w;
        end
    end

    // Access level from the entered code
    logic [1:0] access_w;
    always_comb begin
        access_w = ACC_NONE;
        if (code_q != 8'h00 && prog_disable_lvl1_i && entered_w == code_q)
            access_w = (code_q >= CODE_PROG_MIN) ? ACC_PROG : ACC_PROT;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial print sequencer: address digits, label, value, pause; abbreviated sends the value digits only, with no pause
    typedef enum logic [4:0] {
        CUF_IDLE  = 5'b00001,
        CUF_LOAD  = 5'b00010,
        CUF_SEND  = 5'b00100,
        CUF_NEXT  = 5'b01000,
        CUF_PAUSE = 5'b10000
    } cuf_state_t;
    cuf_state_t st_q;

    logic [3:0]  idx_q;
    logic [9:0]  shreg_q;
    logic [3:0]  bitn_q;
    logic [16:0] bitcnt_q;
    logic [31:0] pause_q;
    logic [16:0] bit_len_w;
    logic [7:0]  ch_w;
    logic [3:0]  last_w;

    always_comb begin
        case (baud_w)
            BAUD_1200: bit_len_w = BIT_1200;
            BAUD_2400: bit_len_w = BIT_2400;
            BAUD_4800: bit_len_w = BIT_4800;
            default:   bit_len_w = BIT_9600;
        endcase
    end

    // Abbreviated: 8 hex digits only; full: 2 address, 1 label, 8 digits
    assign last_w = abbr_w ? 4'h7 : 4'ha;
    always_comb begin
        logic [3:0] k;
        logic [3:0] nib;
        k   = abbr_w ? idx_q + 4'h3 : idx_q;
        nib = 4'h0;
        ch_w = 8'h20;
        if (k == 4'h0)
            ch_w = 8'h30 + 8'(addr_w / 7'd10);
        else if (k == 4'h1)
            ch_w = 8'h30 + 8'(addr_w % 7'd10);
        else if (k == 4'h2)
            ch_w = 8'h43;
        else begin
            nib = txdata_q[4*(4'ha - k) +: 4];
            ch_w = (nib < 4'ha) ? 8'h30 + 8'(nib) : 8'h37 + 8'(nib);
        end
    end

    // Frame: start, 8 data or 7 data plus parity, stop
    function automatic logic [9:0] frame(input logic [7:0] c, input logic [1:0] p);
        logic par;
        par = ^c[6:0];
        if (p == PAR_ODD)
            return {1'b1, ~par, c[6:0], 1'b0};
        else if (p == PAR_EVEN)
            return {1'b1, par, c[6:0], 1'b0};
        return {1'b1, c, 1'b0};
    endfunction

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q     <= CUF_IDLE;
            idx_q    <= 4'h0;
            shreg_q  <= 10'h3ff;
            bitn_q   <= 4'h0;
            bitcnt_q <= 17'h00000;
            pause_q  <= '0;
        end else begin
            case (st_q)
                CUF_IDLE: begin
                    idx_q <= 4'h0;
                    if (|prt_w)
                        st_q <= CUF_LOAD;
                end
                CUF_LOAD: begin
                    shreg_q  <= frame(ch_w, par_w);
                    bitn_q   <= 4'h0;
                    bitcnt_q <= 17'h00000;
                    st_q     <= CUF_SEND;
                end
                CUF_SEND: begin
                    if (bitcnt_q == bit_len_w - 17'h1) begin
                        bitcnt_q <= 17'h00000;
                        shreg_q  <= {1'b1, shreg_q[9:1]};
                        bitn_q   <= bitn_q + 4'h1;
                        if (bitn_q == FRAME_BITS - 4'h1)
                            st_q <= CUF_NEXT;
                    end else begin
                        bitcnt_q <= bitcnt_q + 17'h1;
                    end
                end
                CUF_NEXT: begin
                    pause_q <= '0;
                    if (idx_q != last_w) begin
                        idx_q <= idx_q + 4'h1;
                        st_q  <= CUF_LOAD;
                    end else if (abbr_w) begin
                        st_q <= CUF_IDLE;
                    end else begin
                        st_q <= CUF_PAUSE;
                    end
                end
                CUF_PAUSE: begin
                    pause_q <= pause_q + 32'h1;
                    if (pause_q == 32'(PAUSE_CYC - 1))
                        st_q <= CUF_IDLE;
                end
                default: st_q <= CUF_IDLE;
            endcase
        end
    end
    assign tx_o = shreg_q[0];

    // Read mux, registered data
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            prdata_o <= 32'h0000_0000;
        else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                REG_FUNC:   prdata_o <= {16'h0000, func_q};
                REG_CFG:    prdata_o <= cfg_q;
                REG_CODE:   prdata_o <= {24'h000000, code_q};
                REG_STAT:   prdata_o <= {16'h0000, 1'b0, st_q, access_w, act_w, 4'h0};
                REG_TXDATA: prdata_o <= txdata_q;
                default:    prdata_o <= 32'h0000_0000;
            endcase
        end
    end
    logic unused_w;
    assign unused_w = rd_w;
endmodule

// File: cuf_pkg.sv
// Package for the counter user input function block: codes, timings, register map
package cuf_pkg;
    // Clock rate and derived timing
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SCROLL_MS     = 2500;
    localparam int unsigned PAUSE_MS      = 400;
    localparam int unsigned SCROLL_CYC    = CLK_HZ / 1000 * SCROLL_MS;
    localparam int unsigned PAUSE_CYC     = CLK_HZ / 1000 * PAUSE_MS;

    // User input function codes
    localparam logic [3:0] FN_NONE        = 4'h0;
    localparam logic [3:0] FN_HOLD        = 4'h1;
    localparam logic [3:0] FN_HOLD_LVL    = 4'h2;
    localparam logic [3:0] FN_HOLD_EDGE   = 4'h3;
    localparam logic [3:0] FN_RST_LVL     = 4'h4;
    localparam logic [3:0] FN_RST_EDGE    = 4'h5;
    localparam logic [3:0] FN_RST2_LVL    = 4'h6;
    localparam logic [3:0] FN_RST2_EDGE   = 4'h7;
    localparam logic [3:0] FN_RSTALL_LVL  = 4'h8;
    localparam logic [3:0] FN_RSTALL_EDGE = 4'h9;
    localparam logic [3:0] FN_CHG_DISP    = 4'ha;
    localparam logic [3:0] FN_PROG_DIS    = 4'hb;
    localparam logic [3:0] FN_INHIBIT     = 4'hc;
    localparam logic [3:0] FN_PRINT       = 4'hd;
    localparam logic [3:0] FN_RST_OUT     = 4'he;

    // Source indices: three pins then the panel key
    localparam int unsigned N_SRC         = 4;
    localparam int unsigned SRC_IN1       = 0;
    localparam int unsigned SRC_IN2       = 1;
    localparam int unsigned SRC_INB       = 2;
    localparam int unsigned SRC_KEY       = 3;

    // Count input selector modes that free input B
    localparam logic [1:0] SEL_C1_USR     = 2'h1;
    localparam logic [1:0] SEL_C2_USR     = 2'h2;

    // Security code ranges
    localparam logic [7:0] CODE_MAX       = 8'hc7;
    localparam logic [7:0] CODE_PROG_MIN  = 8'h64;
    localparam logic [1:0] ACC_NONE       = 2'h0;
    localparam logic [1:0] ACC_PROT       = 2'h1;
    localparam logic [1:0] ACC_PROG       = 2'h2;

    // Baud selection and bit times
    localparam logic [1:0] BAUD_1200      = 2'h0;
    localparam logic [1:0] BAUD_2400      = 2'h1;
    localparam logic [1:0] BAUD_4800      = 2'h2;
    localparam logic [1:0] BAUD_9600      = 2'h3;
    // 1200 baud needs 17 bits of cycle count
    localparam logic [16:0] BIT_1200      = 17'(CLK_HZ / 1200);
    localparam logic [16:0] BIT_2400      = 17'(CLK_HZ / 2400);
    localparam logic [16:0] BIT_4800      = 17'(CLK_HZ / 4800);
    localparam logic [16:0] BIT_9600      = 17'(CLK_HZ / 9600);
    localparam logic [1:0] PAR_NONE       = 2'h0;
    localparam logic [1:0] PAR_ODD        = 2'h1;
    localparam logic [1:0] PAR_EVEN       = 2'h2;
    localparam logic [3:0] FRAME_BITS     = 4'ha;

    // APB register map (byte offsets)
    localparam logic [7:0] REG_FUNC       = 8'h00;
    localparam logic [7:0] REG_CFG        = 8'h04;
    localparam logic [7:0] REG_CODE       = 8'h08;
    localparam logic [7:0] REG_STAT       = 8'h0c;
    localparam logic [7:0] REG_TXDATA     = 8'h10;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
endpackage

// File: cuf_top_properties.sv
// Port-level concurrent checks for the counter user input function block
module cuf_top_properties
    import cuf_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    input wire logic [2:0] user_in_i,
    input wire logic       panel_function_key_i,
    input wire logic       display_freeze_o,
    input wire logic       count_inhibit_o,
    input wire logic       outputs_reset_o,
    input wire logic       display_advance_o,
    input wire logic       tx_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus phase and input history sequences
    sequence s_access;
        psel_i && penable_i;
    endsequence
    sequence s_src_rose;
        ({$past(user_in_i, 3), $past(panel_function_key_i, 3)}
            & ~{$past(user_in_i, 4), $past(panel_function_key_i, 4)}) != 4'h0;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answers
    a_pready_high: assert property (pready_o)
        else $error("pready low");
    a_unmapped_err: assert property (s_access ##0 (paddr_i > REG_TXDATA) |-> pslverr_o)
        else $error("unmapped access not refused");
    a_stat_write_err: assert property (s_access ##0 (pwrite_i && paddr_i == REG_STAT) |-> pslverr_o)
        else $error("status write not refused");
    a_err_in_access: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("error outside access phase");

    ////////////////////////////////////////////////////////////////////////////////
    // Input driven outputs, three edges behind the pins
    a_adv_one_pulse: assert property (display_advance_o |=> !display_advance_o)
        else $error("advance longer than one cycle");
    a_orst_one_pulse: assert property (outputs_reset_o |=> !outputs_reset_o)
        else $error("output reset longer than one cycle");
    a_adv_from_edge: assert property (display_advance_o |-> s_src_rose)
        else $error("advance without input edge");
    a_inhibit_cause: assert property (count_inhibit_o |-> $past(user_in_i[0], 3))
        else $error("inhibit without input one");
    a_freeze_cause: assert property (display_freeze_o
        |-> ($past(user_in_i, 3) != 3'h0) || $past(panel_function_key_i, 3))
        else $error("freeze without active source");
    a_start_bit_len: assert property ($fell(tx_o) |-> !tx_o [*8])
        else $error("start bit too short");
endmodule

bind cuf_top cuf_top_properties cuf_top_properties_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .user_in_i(user_in_i), .panel_function_key_i(panel_function_key_i),
    .display_freeze_o(display_freeze_o), .count_inhibit_o(count_inhibit_o),
    .outputs_reset_o(outputs_reset_o), .display_advance_o(display_advance_o), .tx_o(tx_o));

// File: cuf_serial_rx.sv
// Serial receiver model on the far side of the print line
module cuf_serial_rx (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic tx_i,
    output int        low_len_o,
    output logic      framed_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int run;

    // Length of the first low run only: start bit plus leading zero bits, counted in clock cycles
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            run       <= 0;
            framed_o  <= 1'b0;
            low_len_o <= 0;
        end else if (tx_i === 1'b0) begin
            run <= run + 1;
        end else if (run != 0 && !framed_o) begin
            low_len_o <= run;
            framed_o  <= 1'b1;
        end
    end
endmodule

// File: cuf_top_test.sv
// Self-checking bench for the counter user input function block
module cuf_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import cuf_pkg::*;

    logic        ref_clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0]  user_in = 0;
    logic        key = 0, batch = 0, pready, pslverr, er, c1_q = 0, c2_q = 0, inb_ok = 0;
    logic        frz, c1, c2, inh, pd, orst, adv, tx, framed;
    logic [3:0]  fn [4] = '{default: 4'h0};
    logic        lv [4] = '{default: 1'b0};
    int          miscompares = 0, check_count = 0, seed = 73, low_len;
    int          adv_n = 0, orst_n = 0, c1r_n = 0, c2r_n = 0;
    int          exp_adv = 0, exp_orst = 0, exp_c1r = 0, exp_c2r = 0;
    logic [15:0] bad_tab [6] = '{16'h0011, 16'h00c0, 16'hb000, 16'hc000, 16'h0006, 16'h000f};

    cuf_top cuf_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .user_in_i(user_in),
        .panel_function_key_i(key), .batch_model_i(batch), .prog_disable_lvl1_i(1'b0),
        .display_freeze_o(frz), .counter1_reset_o(c1), .counter2_reset_o(c2),
        .count_inhibit_o(inh), .program_disable_o(pd), .outputs_reset_o(orst),
        .display_advance_o(adv), .tx_o(tx));
    cuf_serial_rx cuf_serial_rx_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tx_i(tx),
        .low_len_o(low_len), .framed_o(framed));

    always #5 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse and rising-edge counters on the outputs
    always @(posedge ref_clk_i) begin
        adv_n  <= adv_n + int'(adv === 1'b1);
        orst_n <= orst_n + int'(orst === 1'b1);
        c1r_n  <= c1r_n + int'(c1 === 1'b1 && !c1_q);
        c2r_n  <= c2r_n + int'(c2 === 1'b1 && !c2_q);
        c1_q   <= c1;
        c2_q   <= c2;
    end

    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk_i);
        penable <= 1'b1;
        // The first edge that sees pready high ends this wait
        do @(posedge ref_clk_i);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Level outputs expected from the active sources: freeze, c1, c2, inhibit, disable
    function automatic logic [4:0] model();
        logic [4:0] m;
        m = 5'h00;
        for (int s = 0; s < 4; s++) if (lv[s] && (s != 2 || inb_ok)) case (fn[s])
            FN_HOLD, FN_HOLD_EDGE: m[4] = 1'b1;
            FN_HOLD_LVL:           m[4:2] = batch ? 3'b101 : 3'b110;
            FN_RST_LVL:            m[3] = 1'b1;
            FN_RST2_LVL:           m[2] = 1'b1;
            FN_RSTALL_LVL:         m[3:2] = 2'b11;
            FN_INHIBIT:            m[1] = 1'b1;
            FN_PROG_DIS:           m[0] = 1'b1;
            default: ;
        endcase
        return m;
    endfunction

    function automatic logic fn_bad(input logic [15:0] w);
        int holds;
        logic [3:0] f;
        logic bad;
        holds = 0;
        bad = 1'b0;
        for (int s = 0; s < 4; s++) begin
            f = w[s*4 +: 4];
            holds += int'(f inside {FN_HOLD, FN_HOLD_LVL, FN_HOLD_EDGE});
            bad |= (f == FN_INHIBIT && s != 0) || (f == FN_PROG_DIS && s == 3) || f > FN_RST_OUT
                || (!batch && f inside {FN_RST2_LVL, FN_RST2_EDGE, FN_RSTALL_LVL, FN_RSTALL_EDGE});
        end
        return bad || holds > 1;
    endfunction

    task automatic set_fn(input logic [15:0] w);
        apb(1'b1, REG_FUNC, {16'h0, w});
        cmp(er, fn_bad(w));
        if (!fn_bad(w)) for (int s = 0; s < 4; s++) fn[s] = w[s*4 +: 4];
    endtask

    task automatic set_cfg(input logic [1:0] sel);
        apb(1'b1, REG_CFG, {17'h0, 7'd42, 1'b0, PAR_NONE, BAUD_9600, 1'b0, sel});
        inb_ok = (sel == SEL_C1_USR || sel == SEL_C2_USR);
    endtask

    // Drive one source, then compare levels and pulse counts after sync latency
    task automatic drive(input int s, input logic v);
        logic [4:0] n;
        logic o1, o2, up;
        o1 = model() >> 3;
        o2 = model() >> 2;
        up = v && !lv[s] && (s != 2 || inb_ok);
        lv[s] = v;
        n = model();
        exp_c1r += int'(n[3] && !o1);
        exp_c2r += int'(n[2] && !o2);
        if (up) case (fn[s])
            FN_RST_EDGE:    exp_c1r += int'(!n[3]);
            FN_HOLD_EDGE:   if (batch) exp_c2r += int'(!n[2]); else exp_c1r += int'(!n[3]);
            FN_RST2_EDGE:   exp_c2r += int'(!n[2]);
            FN_RSTALL_EDGE: begin exp_c1r += int'(!n[3]); exp_c2r += int'(!n[2]); end
            FN_CHG_DISP:    exp_adv++;
            FN_RST_OUT:     exp_orst++;
            default: ;
        endcase
        @(posedge ref_clk_i);
        if (s == 3) key <= v;
        else user_in[s] <= v;
        repeat (6) @(posedge ref_clk_i);
        cmp({frz, c1, c2, inh, pd}, n);
        cmp(c1r_n, exp_c1r);
        cmp(c2r_n, exp_c2r);
        cmp(adv_n, exp_adv);
        cmp(orst_n, exp_orst);
    endtask

    task automatic run_set(input logic [15:0] w);
        set_fn(w);
        for (int s = 0; s < 4; s++) begin
            drive(s, 1'b1);
            drive(s, 1'b0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] code;
        int n;
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        cmp({frz, c1, c2, inh, pd, orst, adv, tx}, 8'h01);
        apb(1'b0, REG_CFG, 32'h0);
        cmp(rd, CFG_RESET);
        apb(1'b0, 8'h14, 32'h0);
        cmp(er, 1'b1);
        apb(1'b1, REG_STAT, 32'h0);
        cmp(er, 1'b1);
        // Last pass is one above the top code and must be refused
        for (int i = 0; i < 7; i++) begin
            code = (i == 5) ? 8'(unsigned'($random(seed)) % 200) : 8'(50 * i - (i > 0));
            if (i == 6) code = CODE_MAX + 8'h01;
            apb(1'b1, REG_CODE, {24'h0, code});
            cmp(er, code > CODE_MAX);
        end
        set_cfg(SEL_C1_USR);
        for (int i = 0; i < 6; i++) set_fn(bad_tab[i]);
        run_set(16'h154c);
        run_set(16'h43ea);
        n = 2 + (unsigned'($random(seed)) % 4);
        for (int i = 0; i < n; i++) begin
            drive(0, 1'b1);
            drive(0, 1'b0);
        end
        set_cfg(2'h0);
        drive(2, 1'b1);
        drive(2, 1'b0);
        set_cfg(SEL_C2_USR);
        batch <= 1'b1;
        run_set(16'h8296);
        run_set(16'h0b07);
        set_fn(16'h00d0);
        apb(1'b1, REG_TXDATA, $random(seed));
        cmp(tx, 1'b1);
        drive(1, 1'b1);
        n = 0;
        while (framed !== 1'b1 && n < 70000) begin
            @(posedge ref_clk_i);
            n++;
        end
        cmp(framed, 1'b1);
        // Address 42 leads with '4': start bit plus two low data bits
        cmp(low_len, 3 * int'(BIT_9600));
        drive(1, 1'b0);
        summarize();
    end

    // Hang guard: the print wait is about 32k cycles, the rest well under 1k
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        miscompares++;
        summarize();
    end
endmodule
